// >>> core/oswm_chan.sv
`timescale 1ns/1ps
module oswm_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trig_i,
  input wire logic en_i,
  input wire logic inv_i,
  input wire logic edge_sel_i,
  input wire logic sw_i,
  output logic trig_o
);
  oswm_pkg::oswm_chan_state_t state_reg;
  oswm_pkg::oswm_chan_state_t state_next;
  logic gated;
  logic shaped;

  always_comb begin
    state_next = state_reg;
    gated = (trig_i & en_i) ^ inv_i;
    // edge mode: one cycle on each rise of the gated line
    shaped = edge_sel_i ? (gated & ~state_reg.prev) : gated;
    state_next.prev = gated;
    // software drive is already shaped by its own edge field
    state_next.out = shaped | sw_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign trig_o = state_reg.out;
endmodule // oswm_chan

// >>> core/oswm_defs.svh
`ifndef OSWM_DEFS_SVH
`define OSWM_DEFS_SVH

// ==========================================================
// geometry
`define OSWM_NUM_CH 16
`define OSWM_DIRECT_GROUP 5'h08
`define OSWM_DMA_FIRST 8
// ==========================================================
// register offsets (byte addresses)
`define OSWM_CTL_BASE 8'h00
`define OSWM_CTL_LAST 8'h3c
`define OSWM_CMD_ADDR 8'h40
`define OSWM_STAT_ADDR 8'h44
// ==========================================================
// control fields
`define OSWM_CTL_EN_BIT 0
`define OSWM_CTL_INV_BIT 8
`define OSWM_CTL_EDGE_BIT 12
// ==========================================================
// command fields
`define OSWM_CMD_NUM_LSB 0
`define OSWM_CMD_NUM_MSB 7
`define OSWM_CMD_GRP_LSB 8
`define OSWM_CMD_GRP_MSB 12
`define OSWM_CMD_SIDE_BIT 16
`define OSWM_CMD_EDGE_BIT 17
`define OSWM_CMD_ACT_BIT 31
// ==========================================================
// reset values
`define OSWM_CTL_RESET 3'h0
`define OSWM_CMD_RESET 16'h0000
`endif

// >>> core/oswm_pkg.sv
package oswm_pkg;
  typedef struct packed {
    logic en;
    logic inv;
    logic edge_sel;
  } oswm_ctl_t;

  typedef struct packed {
    logic activate;
    logic edge_sel;
    logic side;
    logic [4:0] group;
    logic [7:0] num;
  } oswm_cmd_t;

  typedef struct packed {
    logic [15:0] stage1;
    logic [15:0] stage2;
  } oswm_sync_state_t;

  typedef struct packed {
    logic prev;
    logic out;
  } oswm_chan_state_t;

  typedef struct packed {
    oswm_ctl_t [15:0] ctl;
    oswm_cmd_t cmd;
    logic [15:0] sw_vec;
    logic mux_act;
    logic [4:0] mux_group;
    logic [7:0] mux_num;
    logic mux_side;
    logic mux_edge;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } oswm_top_state_t;
endpackage

// >>> core/oswm_sync.sv
`timescale 1ns/1ps
module oswm_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] async_i,
  output logic [15:0] sync_o
);
  oswm_pkg::oswm_sync_state_t state_reg;
  oswm_pkg::oswm_sync_state_t state_next;

  // stage1 is read only by stage2
  always_comb begin
    state_next = state_reg;
    state_next.stage1 = async_i;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stage2;
endmodule // oswm_sync

// >>> core/oswm_top.sv
`timescale 1ns/1ps
`include "oswm_defs.svh"
module oswm_top (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // direct routing group: serial tx/rx triggers in, dma inputs 8..23 out
  input wire logic [15:0] DIRECT_ROUTE_INPUT_I,
  output logic [15:0] DIRECT_ROUTE_OUTPUT_O,
  // software activation toward the multiplexed groups
  output logic SW_MUX_ACTIVATE_O,
  output logic [4:0] SW_MUX_GROUP_O,
  output logic [7:0] SW_MUX_TRIG_NUM_O,
  output logic SW_MUX_SIDE_O,
  output logic SW_MUX_EDGE_O
);
  oswm_pkg::oswm_top_state_t state_reg;
  oswm_pkg::oswm_top_state_t state_next;
  logic [15:0] in_sync;
  logic [15:0] route_out;
  logic access;
  logic commit;
  logic wr_commit;
  logic ctl_hit;
  logic [3:0] ctl_idx;
  logic cmd_hit;
  logic stat_hit;
  logic mapped;
  logic cmd_direct;
  logic cmd_in_range;
  logic [31:0] rd_word;

  // ==========================================================
  // input synchroniser
  // peripheral triggers come from foreign logic timing, so two flops first
  oswm_sync u_sync (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .async_i(DIRECT_ROUTE_INPUT_I),
    .sync_o(in_sync)
  );

  // ==========================================================
  // direct channels
  // channel k: even k serial tx, odd k serial rx, to dma input 8+k
  genvar k;
  generate
    for (k = 0; k < `OSWM_NUM_CH; k++) begin : g_chan
      oswm_chan u_chan (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .trig_i(in_sync[k]),
        .en_i(state_reg.ctl[k].en),
        .inv_i(state_reg.ctl[k].inv),
        .edge_sel_i(state_reg.ctl[k].edge_sel),
        .sw_i(state_reg.sw_vec[k]),
        .trig_o(route_out[k])
      );
    end
  endgenerate

  // ==========================================================
  // address decode
  always_comb begin
    access = PSEL_I & PENABLE_I;
    // one wait state: the answer flop rises, then the transfer ends
    commit = access & state_reg.pready;
    wr_commit = commit & PWRITE_I;
    ctl_hit = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= `OSWM_CTL_LAST);
    ctl_idx = PADDR_I[5:2];
    cmd_hit = (PADDR_I == `OSWM_CMD_ADDR);
    stat_hit = (PADDR_I == `OSWM_STAT_ADDR);
    mapped = ctl_hit | cmd_hit | stat_hit;
  end

  // ==========================================================
  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ctl_hit) begin
      rd_word[`OSWM_CTL_EN_BIT] = state_reg.ctl[ctl_idx].en;
      rd_word[`OSWM_CTL_INV_BIT] = state_reg.ctl[ctl_idx].inv;
      rd_word[`OSWM_CTL_EDGE_BIT] = state_reg.ctl[ctl_idx].edge_sel;
    end else if (cmd_hit) begin
      rd_word[`OSWM_CMD_NUM_MSB:`OSWM_CMD_NUM_LSB] = state_reg.cmd.num;
      rd_word[`OSWM_CMD_GRP_MSB:`OSWM_CMD_GRP_LSB] = state_reg.cmd.group;
      rd_word[`OSWM_CMD_SIDE_BIT] = state_reg.cmd.side;
      rd_word[`OSWM_CMD_EDGE_BIT] = state_reg.cmd.edge_sel;
      // reads back zero once an edge activation has fired
      rd_word[`OSWM_CMD_ACT_BIT] = state_reg.cmd.activate;
    end else if (stat_hit) begin
      rd_word = {route_out, in_sync};
    end
  end

  // ==========================================================
  // software command target
  always_comb begin
    cmd_direct = (state_reg.cmd.group == `OSWM_DIRECT_GROUP);
    // a direct group has only 16 outputs; higher numbers address nothing
    cmd_in_range = (state_reg.cmd.num < 8'(`OSWM_NUM_CH));
  end

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;

    // apb answer
    state_next.pready = access & ~state_reg.pready;
    state_next.pslverr = access & ~state_reg.pready & ~mapped;
    state_next.prdata = 32'h0000_0000;
    if (access & ~state_reg.pready & ~PWRITE_I) begin
      state_next.prdata = rd_word;
    end

    // edge activation lives exactly one cycle, then clears itself
    if (state_reg.cmd.activate & state_reg.cmd.edge_sel) begin
      state_next.cmd.activate = 1'b0;
    end

    // register writes; a software write wins over the self clear
    if (wr_commit & ctl_hit) begin
      state_next.ctl[ctl_idx].en = PWDATA_I[`OSWM_CTL_EN_BIT];
      state_next.ctl[ctl_idx].inv = PWDATA_I[`OSWM_CTL_INV_BIT];
      state_next.ctl[ctl_idx].edge_sel = PWDATA_I[`OSWM_CTL_EDGE_BIT];
    end
    if (wr_commit & cmd_hit) begin
      // fields and activate are both taken; software keeps them apart
      state_next.cmd.num = PWDATA_I[`OSWM_CMD_NUM_MSB:`OSWM_CMD_NUM_LSB];
      state_next.cmd.group = PWDATA_I[`OSWM_CMD_GRP_MSB:`OSWM_CMD_GRP_LSB];
      state_next.cmd.side = PWDATA_I[`OSWM_CMD_SIDE_BIT];
      state_next.cmd.edge_sel = PWDATA_I[`OSWM_CMD_EDGE_BIT];
      state_next.cmd.activate = PWDATA_I[`OSWM_CMD_ACT_BIT];
    end

    // drive the addressed line while activate stands
    state_next.sw_vec = 16'h0000;
    state_next.mux_act = 1'b0;
    if (state_reg.cmd.activate) begin
      if (cmd_direct) begin
        // direct groups: output only, side select ignored
        if (cmd_in_range) begin
          state_next.sw_vec[state_reg.cmd.num[3:0]] = 1'b1;
        end
      end else begin
        state_next.mux_act = 1'b1;
      end
    end
    state_next.mux_group = state_reg.cmd.group;
    state_next.mux_num = state_reg.cmd.num;
    state_next.mux_side = state_reg.cmd.side;
    state_next.mux_edge = state_reg.cmd.edge_sel;
  end

  // ==========================================================
  // state register
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign PRDATA_O = state_reg.prdata;
  assign PREADY_O = state_reg.pready;
  assign PSLVERR_O = state_reg.pslverr;
  assign DIRECT_ROUTE_OUTPUT_O = route_out;
  assign SW_MUX_ACTIVATE_O = state_reg.mux_act;
  assign SW_MUX_GROUP_O = state_reg.mux_group;
  assign SW_MUX_TRIG_NUM_O = state_reg.mux_num;
  assign SW_MUX_SIDE_O = state_reg.mux_side;
  assign SW_MUX_EDGE_O = state_reg.mux_edge;
endmodule // oswm_top

// >>> verification/oswm_peer.sv
`timescale 1ns/1ps
// ==========
// trigger sources: change just after the edge, like real logic
module oswm_peer (
  input wire logic clk_i,
  input wire logic [15:0] lvl_i,
  output logic [15:0] trig_o
);
  always_ff @(posedge clk_i) begin
    trig_o <= lvl_i;
  end
endmodule // oswm_peer

// >>> verification/oswm_top_monitor.sv
`timescale 1ns/1ps
module oswm_top_monitor (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic SW_MUX_ACTIVATE_O,
  input wire logic [4:0] SW_MUX_GROUP_O,
  input wire logic SW_MUX_EDGE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  wire logic acc = PSEL_I && PENABLE_I && !PREADY_O;
  wire logic cmd = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && PADDR_I == 8'h40;
  wire logic act = cmd && PWDATA_I[31];
  // ==========
  // register bus
  property p_wait; acc |=> PREADY_O; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_pulse; PREADY_O |=> !PREADY_O; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; acc && PADDR_I > 8'h44 |=> PSLVERR_O && PRDATA_O == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped ok");
  property p_ok; acc && PADDR_I <= 8'h44 && PADDR_I[1:0] == 2'h0 |=> !PSLVERR_O; endproperty
  a_ok: assert property (p_ok) else $error("mapped err");
  property p_idle; !PREADY_O |-> PRDATA_O == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stale data");
  // ==========
  // software command
  property p_mux; SW_MUX_ACTIVATE_O |-> SW_MUX_GROUP_O != 5'h08; endproperty
  a_mux: assert property (p_mux) else $error("direct on mux");
  property p_act; act && PWDATA_I[12:8] != 5'h08 |-> ##[1:2] SW_MUX_ACTIVATE_O; endproperty
  a_act: assert property (p_act) else $error("no activation");
  property p_grp; cmd |-> ##2 SW_MUX_GROUP_O == $past(PWDATA_I[12:8], 2); endproperty
  a_grp: assert property (p_grp) else $error("group copy");
  property p_edge; $rose(SW_MUX_ACTIVATE_O) && SW_MUX_EDGE_O |=> !SW_MUX_ACTIVATE_O; endproperty
  a_edge: assert property (p_edge) else $error("edge held");
  // only writes may drop a level activation, so quiet bus means it holds
  property p_level;
    SW_MUX_ACTIVATE_O && !SW_MUX_EDGE_O && !PSEL_I && !$past(PSEL_I) |=> SW_MUX_ACTIVATE_O;
  endproperty
  a_level: assert property (p_level) else $error("level dropped");
endmodule // oswm_top_monitor
bind oswm_top oswm_top_monitor mon_u (.CORE_CLK_I, .RESET_I, .PSEL_I, .PENABLE_I,
  .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O,
  .SW_MUX_ACTIVATE_O, .SW_MUX_GROUP_O, .SW_MUX_EDGE_O);

// >>> verification/oswm_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module oswm_top_tb;
  typedef struct packed {logic [2:0] c; logic i; logic o;} oswm_row_t;
  // ctl {edge, inv, en}, input, expected output
  localparam oswm_row_t ROWS [5] = '{5'b00111, 5'b00010, 5'b01110, 5'b01001, 5'b01101};
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, act, side, edg, pready, pslverr, er;
  logic [7:0] paddr = 8'h00, num;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] lvl = 16'h0, din, dout, exp;
  logic [4:0] grp;
  int failures = 0, num_checks = 0, n;
  always #12.5 clk = ~clk;
  oswm_peer peer_u (.clk_i(clk), .lvl_i(lvl), .trig_o(din));
  oswm_top dut_u (.CORE_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .DIRECT_ROUTE_INPUT_I(din),
    .DIRECT_ROUTE_OUTPUT_O(dout), .SW_MUX_ACTIVATE_O(act), .SW_MUX_GROUP_O(grp),
    .SW_MUX_TRIG_NUM_O(num), .SW_MUX_SIDE_O(side), .SW_MUX_EDGE_O(edg));
  // ==========
  // tasks
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // read right at the edge: outputs still hold what this edge samples
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // fields first, activate in a write of its own
  task automatic swt(input logic [31:0] f);
    apb(1, 8'h40, f);
    apb(1, 8'h40, f | 32'h80000000);
  endtask
  task automatic cnt(input int b);
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += ((b < 16 ? dout[b] : act) === 1'b1);
    end
  endtask
  // ==========
  // sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(0, 8'h00, 0);
    `CHK({er, rd}, 33'h0)
    apb(0, 8'h40, 0);
    `CHK(rd, 32'h0)
    apb(0, 8'h80, 0);
    `CHK({er, rd}, 33'h100000000)
    for (int k = 0; k < 16; k++) begin
      apb(1, 8'(4 * k), {19'h0, ROWS[k % 5].c[2], 3'h0, ROWS[k % 5].c[1], 7'h0, ROWS[k % 5].c[0]});
      apb(0, 8'(4 * k), 0);
      `CHK(rd[0], ROWS[k % 5].c[0])
      `CHK({rd[12], rd[8]}, ROWS[k % 5].c[2:1])
      lvl[k] <= ROWS[k % 5].i;
      exp[k] = ROWS[k % 5].o;
    end
    repeat (6) @(posedge clk);
    `CHK(dout, exp)
    apb(0, 8'h44, 0);
    `CHK(rd, {exp, lvl})
    apb(1, 8'h14, 32'h1001);
    lvl[5] <= 1'b0;
    repeat (6) @(posedge clk);
    lvl[5] <= 1'b1;
    cnt(5);
    `CHK(n, 1)
    // channel 1 is blocked, so any high comes from software
    swt(32'h10801);
    repeat (4) @(posedge clk);
    `CHK(dout[1], 1'b1)
    apb(1, 8'h40, 32'h801);
    repeat (4) @(posedge clk);
    `CHK(dout[1], 1'b0)
    swt(32'h20801);
    cnt(1);
    `CHK(n, 1)
    apb(0, 8'h40, 0);
    `CHK(rd[31], 1'b0)
    // number 16 in the direct group reaches no channel and no mux line
    swt(32'h10810);
    repeat (4) @(posedge clk);
    exp[5] = 1'b0;
    `CHK({act, dout}, {1'b0, exp})
    apb(1, 8'h40, 32'h810);
    for (int s = 0; s < 2; s++) begin
      swt(32'h20305 | (s << 16));
      cnt(16);
      `CHK(n, 1)
      `CHK({grp, num, side}, {5'h03, 8'h05, 1'(s)})
    end
    swt(32'h305);
    repeat (4) @(posedge clk);
    `CHK(act, 1'b1)
    apb(1, 8'h40, 32'h305);
    repeat (4) @(posedge clk);
    `CHK(act, 1'b0)
    // reset in mid-run clears routing and command state
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({act, pready, dout}, 18'h0)
    rst <= 1'b0;
    apb(0, 8'h00, 0);
    `CHK(rd, 32'h0)
    apb(0, 8'h40, 0);
    `CHK(rd, 32'h0)
    `CHK(dout, 16'h0)
    summarize();
  end
endmodule // oswm_top_tb
